// file: dv/sarcc_analog_model.sv
// sarcc_analog_model: far-side analog model, a held level and an ideal comparator
// assumes the level is stable for the whole of a conversion
module sarcc_analog_model (
    input  wire logic [15:0] sar_trial_i,  // dac trial code from the block
    input  wire logic [15:0] level_i,      // held input as a code
    output logic             comparator_o  // 1 = keep trial bit
);
    timeunit 1ns;
    timeprecision 1ps;
    // keep the bit while the trial does not exceed the level
    assign comparator_o = (sar_trial_i <= level_i);
endmodule // sarcc_analog_model

// file: dv/sarcc_ctrl_test.sv
// sarcc_ctrl_test: self-checking bench of the conversion control block
// assumes the analog model in dv and the package in hdl are compiled first
module sarcc_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    import sarcc_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    sarcc_pins_type pins = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    logic [15:0] vin = 16'h0000;
    logic comparator_i, sample_hold_o, busy_o, power_reduced_o, parallel_oe_o;
    logic serial_result_out_o, serial_oe_o, read_incomplete_flag_o;
    logic [15:0] sar_trial_o, parallel_data_o, v;
    logic [15:0] exp_q[$];
    int n_fail = 0;
    int checks_done = 0;
    int flag_cnt = 0;
    bit keep_low = 1'b0;
    logic [31:0] rng = 32'h0000_0035;
    // free-running system clock
    always #25 clk_sys_i = ~clk_sys_i;
    // counts error pulses
    always @(posedge clk_sys_i) if (read_incomplete_flag_o === 1'b1) flag_cnt++;
    sarcc_ctrl sarcc_ctrl_inst (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .pins_i(pins), .comparator_i(comparator_i),
        .sample_hold_o(sample_hold_o), .sar_trial_o(sar_trial_o), .busy_o(busy_o),
        .power_reduced_o(power_reduced_o), .parallel_data_o(parallel_data_o),
        .parallel_oe_o(parallel_oe_o), .serial_result_out_o(serial_result_out_o),
        .serial_oe_o(serial_oe_o), .read_incomplete_flag_o(read_incomplete_flag_o));
    sarcc_analog_model sarcc_analog_model_inst (
        .sar_trial_i(sar_trial_o), .level_i(vin), .comparator_o(comparator_i));
    function automatic logic [15:0] rand16();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng[15:0];
    endfunction
    task automatic end_of_test();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic wait_busy(input logic lvl, input int lim);
        int k;
        k = 0;
        while (busy_o !== lvl && k < lim) begin
            @(posedge clk_sys_i);
            k++;
        end
        if (busy_o !== lvl) begin
            check(busy_o, lvl);
            end_of_test();
        end
    endtask
    // falling start, then wait for busy and hold
    task automatic begin_conv(input logic [15:0] val);
        pins.conversion_start_n <= 1'b0;
        vin <= val;
        exp_q.push_back(val);
        wait_busy(1'b1, 60);
        check(sample_hold_o, 1'b1);
    endtask
    // busy length and latched result against the queue
    task automatic end_conv();
        int n;
        n = 0;
        while (busy_o === 1'b1 && n < 60) begin
            @(posedge clk_sys_i);
            n++;
        end
        check(n[15:0], SARCC_BIT_CYC * SARCC_RES_BITS);
        if (n >= 60) end_of_test();
        cyc(2);
        check(parallel_data_o, exp_q.pop_front());
        // raise start, let acquisition end while high so the next fall is a real edge
        if (!keep_low) begin
            pins.conversion_start_n <= 1'b1;
            cyc(24);
        end
    endtask
    task automatic convert(input logic [15:0] val);
        begin_conv(val);
        end_conv();
    endtask
    task automatic sclk_pulse();
        pins.serial_clock <= 1'b1;
        cyc(6);
        pins.serial_clock <= 1'b0;
        cyc(6);
    endtask
    initial begin
        cyc(8);
        rst_n_i <= 1'b1;
        cyc(3);
        check({busy_o, sample_hold_o, parallel_oe_o, serial_oe_o}, 16'h0000);
        // start held low: back-to-back conversions, bounds then random
        keep_low = 1'b1;
        exp_q.delete();
        convert(16'h0000);
        convert(16'hFFFF);
        convert(16'h8000);
        for (int i = 0; i < 3; i++) convert(rand16());
        keep_low = 1'b0;
        pins.conversion_start_n <= 1'b1;
        cyc(60);
        check(busy_o, 1'b0);
        convert(rand16());
        // reset pin in mid-conversion drops the partial result
        begin_conv(16'h7FFF);
        cyc(10);
        pins.reset_pin <= 1'b1;
        pins.conversion_start_n <= 1'b1;
        wait_busy(1'b0, 8);
        cyc(2);
        check(parallel_data_o, SARCC_RESULT_RST);
        void'(exp_q.pop_front());
        pins.reset_pin <= 1'b0;
        cyc(40);
        check({busy_o, sample_hold_o}, 16'h0000);
        convert(16'h1234);
        // power-down while converting: finish, then no starts
        begin_conv(16'hA5C3);
        pins.power_down_request <= 1'b1;
        keep_low = 1'b1;
        end_conv();
        cyc(60);
        check({power_reduced_o, busy_o}, 16'h0002);
        pins.power_down_request <= 1'b0;
        convert(16'h5A3C);
        keep_low = 1'b0;
        pins.conversion_start_n <= 1'b1;
        // bus enable over every select and read combination, both modes
        for (int m = 0; m < 2; m++) begin
            pins.serial_parallel_select <= m[0];
            pins.clock_source_select <= m[0];
            for (int c = 0; c < 4; c++) begin
                pins.chip_select_n <= c[1];
                pins.read_n <= c[0];
                cyc(8);
                check({parallel_oe_o, serial_oe_o}, (c != 0) ? 2'b00 : (m ? 2'b01 : 2'b10));
            end
        end
        // serial mode: gated clock, full read, then an unfinished read
        v = rand16();
        convert(v);
        pins.chip_select_n <= 1'b1;
        cyc(2);
        sclk_pulse();
        sclk_pulse();
        check(serial_result_out_o, v[15]);
        pins.chip_select_n <= 1'b0;
        pins.read_n <= 1'b0;
        cyc(6);
        for (int i = 15; i >= 0; i--) begin
            check(serial_result_out_o, v[i]);
            sclk_pulse();
        end
        flag_cnt = 0;
        v = rand16();
        convert(v);
        cyc(4);
        check(flag_cnt[15:0], 16'h0000);
        check(serial_result_out_o, v[15]);
        sclk_pulse();
        convert(rand16());
        cyc(4);
        check(flag_cnt[15:0], 16'h0001);
        end_of_test();
    end
endmodule // sarcc_ctrl_test

// file: hdl/sarcc_ctrl.sv
// sarcc_ctrl: control logic of a 16-bit successive-approximation converter
// assumes the analog comparator result arrives synchronous to clk_sys_i
module sarcc_ctrl
    import sarcc_pkg::*;
(
    input  wire logic                  clk_sys_i,        // 20 MHz system clock
    input  wire logic                  rst_n_i,          // synchronous reset, active low
    input  wire sarcc_pkg::sarcc_pins_type pins_i,       // raw host pins
    input  wire logic                  comparator_i,     // sar comparator, 1 = keep bit
    output logic                       sample_hold_o,    // 1 = hold, 0 = track
    output logic [15:0]                sar_trial_o,      // dac trial code
    output logic                       busy_o,           // conversion running
    output logic                       power_reduced_o,  // reduced power state
    output logic [15:0]                parallel_data_o,  // parallel result bus
    output logic                       parallel_oe_o,    // parallel bus enable
    output logic                       serial_result_out_o, // serial result bit
    output logic                       serial_oe_o,      // serial output enable
    output logic                       read_incomplete_flag_o // one-cycle error pulse
);
    import sarcc_pkg::*;

    // synchronised pin levels
    logic start_n_s, pd_s, rst_pin_s, cs_n_s, rd_n_s, sclk_s, ser_s, ext_s;
    sarcc_pins_type rst_levels;
    assign rst_levels = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

    sarcc_sync u_sync_start (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .rst_val_i(rst_levels.conversion_start_n), .pin_i(pins_i.conversion_start_n),
        .level_o(start_n_s));
    sarcc_sync u_sync_pd (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .rst_val_i(rst_levels.power_down_request), .pin_i(pins_i.power_down_request),
        .level_o(pd_s));
    sarcc_sync u_sync_rst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .rst_val_i(rst_levels.reset_pin), .pin_i(pins_i.reset_pin), .level_o(rst_pin_s));
    sarcc_sync u_sync_cs (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .rst_val_i(rst_levels.chip_select_n), .pin_i(pins_i.chip_select_n),
        .level_o(cs_n_s));
    sarcc_sync u_sync_rd (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .rst_val_i(rst_levels.read_n), .pin_i(pins_i.read_n), .level_o(rd_n_s));
    sarcc_sync u_sync_sclk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .rst_val_i(rst_levels.serial_clock), .pin_i(pins_i.serial_clock),
        .level_o(sclk_s));
    sarcc_sync u_sync_ser (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .rst_val_i(rst_levels.serial_parallel_select),
        .pin_i(pins_i.serial_parallel_select), .level_o(ser_s));
    sarcc_sync u_sync_ext (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .rst_val_i(rst_levels.clock_source_select), .pin_i(pins_i.clock_source_select),
        .level_o(ext_s));

    // combined reset: system reset or reset pin
    logic clr;
    assign clr = !rst_n_i || rst_pin_s;

    // previous levels for edge detection
    logic start_n_d_r, sclk_d_r;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            start_n_d_r <= 1'b1;
            sclk_d_r    <= 1'b0;
        end else begin
            start_n_d_r <= start_n_s;
            sclk_d_r    <= sclk_s;
        end
    end
    logic start_fall;
    assign start_fall = start_n_d_r && !start_n_s;

    // state machine and counters
    sarcc_state_type state_r;
    logic [15:0]     acq_cnt_r;
    logic [4:0]      bit_idx_r;
    logic [7:0]      step_cnt_r;
    logic [15:0]     sar_r;
    logic            conv_done;
    logic            acq_done;

    assign acq_done  = (acq_cnt_r >= 16'(SARCC_ACQ_CYC - 1));
    assign conv_done = (state_r == SARCC_CONV) && (bit_idx_r == 5'd0)
                       && (step_cnt_r == 8'(SARCC_BIT_CYC - 1));

    // acquisition timer runs only in the acquisition phase
    always_ff @(posedge clk_sys_i) begin
        if (clr || state_r != SARCC_ACQ) begin
            acq_cnt_r <= 16'h0000;
        end else if (!acq_done) begin
            acq_cnt_r <= acq_cnt_r + 16'h0001;
        end
    end

    // phase sequencing
    always_ff @(posedge clk_sys_i) begin
        if (clr) begin
            state_r <= SARCC_ACQ;
        end else begin
            unique case (state_r)
                SARCC_ACQ: begin
                    if (pd_s) begin
                        state_r <= SARCC_PWRDN;
                    end else if (acq_done) begin
                        if (!start_n_s) begin
                            state_r <= SARCC_CONV;
                        end else begin
                            state_r <= SARCC_WAIT_EDGE;
                        end
                    end
                end
                SARCC_WAIT_EDGE: begin
                    if (pd_s) begin
                        state_r <= SARCC_PWRDN;
                    end else if (start_fall) begin
                        state_r <= SARCC_CONV;
                    end
                end
                SARCC_CONV: begin
                    if (conv_done) begin
                        state_r <= pd_s ? SARCC_PWRDN : SARCC_ACQ;
                    end
                end
                SARCC_PWRDN: begin
                    if (!pd_s) begin
                        state_r <= SARCC_ACQ;
                    end
                end
            endcase
        end
    end

    // successive approximation, msb first
    always_ff @(posedge clk_sys_i) begin
        if (clr || state_r != SARCC_CONV) begin
            bit_idx_r  <= 5'(SARCC_RES_BITS - 1);
            step_cnt_r <= 8'h00;
            sar_r      <= 16'h8000;
        end else if (step_cnt_r == 8'(SARCC_BIT_CYC - 1)) begin
            step_cnt_r <= 8'h00;
            sar_r[bit_idx_r[3:0]] <= comparator_i;
            if (bit_idx_r != 5'd0) begin
                sar_r[bit_idx_r[3:0] - 4'd1] <= 1'b1;
                bit_idx_r <= bit_idx_r - 5'd1;
            end
        end else begin
            step_cnt_r <= step_cnt_r + 8'h01;
        end
    end

    logic [15:0] final_code;
    always_comb begin
        final_code    = sar_r;
        final_code[0] = comparator_i;
    end

    assign sample_hold_o   = (state_r == SARCC_CONV);
    assign busy_o          = (state_r == SARCC_CONV);
    assign power_reduced_o = (state_r == SARCC_PWRDN);
    assign sar_trial_o     = sar_r;

    // result register and serial shift register
    logic [15:0] result_r;
    logic [15:0] shift_r;
    logic [4:0]  sent_r;
    logic        serial_ext;
    logic        sclk_rise;
    assign serial_ext = ser_s && ext_s;
    assign sclk_rise  = !cs_n_s && sclk_s && !sclk_d_r;

    always_ff @(posedge clk_sys_i) begin
        if (clr) begin
            result_r <= SARCC_RESULT_RST;
            shift_r  <= SARCC_RESULT_RST;
            sent_r   <= 5'd0;
        end else if (conv_done) begin
            result_r <= final_code;
            shift_r  <= final_code;
            sent_r   <= 5'd0;
        end else if (serial_ext && sclk_rise) begin
            shift_r  <= {shift_r[14:0], 1'b0};
            sent_r   <= (sent_r == 5'd16) ? sent_r : sent_r + 5'd1;
        end
    end

    // read counts as started once a bit moved, complete after all sixteen
    always_ff @(posedge clk_sys_i) begin
        if (clr) begin
            read_incomplete_flag_o <= 1'b0;
        end else begin
            read_incomplete_flag_o <= conv_done && serial_ext
                && sent_r != 5'd0 && sent_r != 5'd16;
        end
    end

    // bus drivers
    logic bus_en;
    assign bus_en = !cs_n_s && !rd_n_s;
    always_ff @(posedge clk_sys_i) begin
        if (clr) begin
            parallel_data_o     <= 16'h0000;
            serial_result_out_o <= 1'b0;
        end else begin
            parallel_data_o     <= result_r;
            serial_result_out_o <= shift_r[15];
        end
    end
    assign parallel_oe_o = bus_en && !ser_s;
    assign serial_oe_o   = bus_en && ser_s;

    // checks
    property p_busy_flow;
        @(posedge clk_sys_i) disable iff (clr)
        $fell(busy_o) |-> (!sample_hold_o && $past(conv_done)
                           && result_r == $past(final_code));
    endproperty
    a_busy_flow: assert property (p_busy_flow) else $error("busy fell without result");

    property p_abort;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        rst_pin_s |=> !busy_o;
    endproperty
    a_abort: assert property (p_abort) else $error("reset did not abort");

    property p_pd_block;
        @(posedge clk_sys_i) disable iff (clr)
        (pd_s && !busy_o) |=> !$rose(busy_o);
    endproperty
    a_pd_block: assert property (p_pd_block) else $error("start in power-down");

    property p_oe;
        @(posedge clk_sys_i) disable iff (clr)
        (parallel_oe_o || serial_oe_o) |-> (!cs_n_s && !rd_n_s);
    endproperty
    a_oe: assert property (p_oe) else $error("bus enabled without cs/rd");

    property p_wait_edge;
        @(posedge clk_sys_i) disable iff (clr)
        (state_r == SARCC_WAIT_EDGE && !start_fall) |=> !busy_o;
    endproperty
    a_wait_edge: assert property (p_wait_edge) else $error("started without edge");

    property p_immediate;
        @(posedge clk_sys_i) disable iff (clr)
        (state_r == SARCC_ACQ && acq_done && !start_n_s && !pd_s) |=> busy_o;
    endproperty
    a_immediate: assert property (p_immediate) else $error("no immediate start");

    property p_rdflag;
        @(posedge clk_sys_i) disable iff (clr)
        read_incomplete_flag_o |=> !read_incomplete_flag_o;
    endproperty
    a_rdflag: assert property (p_rdflag) else $error("flag not a pulse");

    property p_gate;
        @(posedge clk_sys_i) disable iff (clr)
        (cs_n_s && !conv_done) |=> $stable(shift_r);
    endproperty
    a_gate: assert property (p_gate) else $error("clock not gated");

    property p_after_reset;
        @(posedge clk_sys_i)
        (!rst_n_i) |=> (!busy_o && state_r == SARCC_ACQ);
    endproperty
    a_after_reset: assert property (p_after_reset) else $error("bad reset state");
endmodule // sarcc_ctrl

// file: hdl/sarcc_pkg.sv
// sarcc_pkg: shared constants and carrier types of the conversion control block
// assumes one 20 MHz system clock and a synchronous active-low reset
package sarcc_pkg;
    localparam int unsigned SARCC_RES_BITS      = 16;           // result width
    localparam int unsigned SARCC_CLK_HZ        = 20_000_000;   // system clock rate
    localparam int unsigned SARCC_ACQ_NS        = 1000;         // least acquisition time
    localparam int unsigned SARCC_ACQ_CYC       =
        (SARCC_ACQ_NS * (SARCC_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned SARCC_BIT_CYC       = 2;            // cycles per sar bit step
    localparam logic [15:0] SARCC_RESULT_RST    = 16'h0000;     // result reset value
    localparam int unsigned SARCC_SYNC_STAGES   = 3;            // pin synchroniser depth

    // host-side pins, already raw from outside the clock domain
    typedef struct packed {
        logic conversion_start_n;   // start, active low
        logic power_down_request;   // stop new conversions
        logic reset_pin;            // abort, active high
        logic chip_select_n;        // chip select
        logic read_n;               // read strobe
        logic serial_clock;         // host serial clock
        logic serial_parallel_select; // 1 serial, 0 parallel
        logic clock_source_select;  // 1 external serial clock
    } sarcc_pins_type;

    // conversion control states
    typedef enum logic [1:0] {
        SARCC_ACQ,
        SARCC_WAIT_EDGE,
        SARCC_CONV,
        SARCC_PWRDN
    } sarcc_state_type;
endpackage : sarcc_pkg

// file: hdl/sarcc_sync.sv
// sarcc_sync: three-flop synchroniser with agreement filter for one pin
// assumes the input is asynchronous to clk_sys_i
module sarcc_sync (
    input  wire logic clk_sys_i,   // system clock
    input  wire logic rst_n_i,     // synchronous reset, active low
    input  wire logic rst_val_i,   // level assumed before first sample
    input  wire logic pin_i,       // raw asynchronous pin
    output logic      level_o      // filtered level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // chain plus filter: level moves once stage two and three agree
    always_ff @(posedge clk_sys_i) begin
        s1_r <= pin_i;
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (!rst_n_i) begin
            level_o <= rst_val_i;
        end else if (s2_r == s3_r) begin
            level_o <= s3_r;
        end
    end
endmodule // sarcc_sync
